// ==== pkg/tlic_pkg.sv ====
package tlic_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_INT_ENABLE = 8'hA8;
  localparam logic [7:0] IDX_INT_ENABLE_SECOND = 8'hAF;
  localparam logic [7:0] IDX_SERIAL_PERIPH_STATUS = 8'hCD;
  localparam logic [7:0] IDX_SPI_DATA_REG = 8'hCF;
  localparam logic [7:0] IDX_COUNTER_ARRAY_CONTROL = 8'hD8;
  localparam logic [7:0] IDX_COUNTER_ARRAY_MODE = 8'hD9;
  localparam logic [7:0] IDX_COMPARE_MODULE0_MODE = 8'hDA;
  localparam logic [7:0] IDX_COMPARE_MODULE1_MODE = 8'hDB;
  localparam logic [7:0] IDX_PRIORITY_SELECT = 8'hE0;
  localparam logic [7:0] IDX_PRIORITY_SELECT_SECOND = 8'hE1;
  localparam logic [7:0] IDX_COMPARE_VALUE0 = 8'hE2;
  localparam logic [7:0] IDX_COMPARE_VALUE1 = 8'hE3;
  localparam logic [7:0] IDX_SERVICE_STATE = 8'hE4;
  // field positions
  localparam int B_GLOBAL_IRQ_GATE = 7;
  localparam int B_SPI_IRQ_ENABLE = 1;
  localparam int B_SERIAL2_IRQ_EN = 0;
  localparam int B_OVERFLOW_IRQ_EN = 0;
  localparam int B_MODULE_EVENT_IRQ_EN = 0;
  localparam int B_MATCH_ENABLE = 3;
  localparam int B_FALLING_CAPTURE_EN = 4;
  localparam int B_RISING_CAPTURE_EN = 5;
  localparam int B_SPI_DONE_FLAG = 7;
  localparam int B_WRITE_COLLISION_FLAG = 6;
  localparam int B_COUNTER_OVERFLOW_FLAG = 7;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COMPARE = 16'h0000;
  // sources and vectors
  localparam int NSRC = 24;
  localparam logic [4:0] SRC_COUNTER_ARRAY = 5'h07;
  localparam logic [4:0] SRC_SERIAL2 = 5'h08;
  localparam logic [4:0] SRC_SPI = 5'h09;
  localparam logic [23:0] SRC_UNUSED = 24'h00E000;
  localparam logic [15:0] VEC_BASE = 16'h0003;

  typedef struct packed {
    logic req;
    logic level;
    logic [4:0] num;
    logic [15:0] vector;
  } tlic_irq_t;

  typedef struct packed {
    logic overflow;
    logic [15:0] count;
    logic [1:0] cap_pin;
  } tlic_pca_t;

  typedef struct packed {
    logic done;
    logic busy;
    logic master;
    logic select_n;
    logic select_ignore;
  } tlic_spi_t;
endpackage

// ==== hw/tlic_top.sv ====
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
// Function
// - counter overflow flag requests only while overflow enable is set
// - each module event flag requests only while its mode bit 0 is set
// - match enable and counter equal compare value sets module event flag
// - capture on rising edge if rising enable, falling edge if falling enable
// - transfer end sets spi done flag; request needs spi and global enable
// - select low in master mode with select_ignore 0 sets done flag
// - writing 1 clears spi done flag, writing 0 leaves it
// - data write during transfer sets collision flag; write 1 clears it
// - global gate 0 blocks all; gate 1 uses per-source enables
// - second enable register bit 1 gates the spi interrupt
// - each source has one of two levels; listed sources stay low
// - high level preempts a low routine; low level does not
// - nothing preempts a running high level routine
// - simultaneous different levels: higher level served first
// - fixed polling order 0..12 and 16..23; 13..15 unused
// - polling order never lets same level preempt a running routine
// - rollover sets overflow flag; software may set, only software clears
// - match or capture sets event flag; stays until software clears
// - vector is 0003H plus eight times source number
module tlic_top
  import tlic_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tlic_pca_t counter_array,
  input wire tlic_spi_t spi,
  input wire logic [23:0] src_flag,
  input wire logic [23:0] src_en,
  input wire logic irq_ack,
  input wire logic irq_reti,
  output tlic_irq_t irq,
  output logic spi_tx_load,
  output logic [7:0] spi_tx_data
);

  function automatic logic [4:0] first_set(input logic [23:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        n = 5'(i);
      end
    end
    return n;
  endfunction

  function automatic logic [15:0] vec_of(input logic [4:0] n);
    return VEC_BASE + {8'h00, n, 3'b000};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] int_enable;
  logic [7:0] int_enable_second;
  logic [7:0] counter_array_mode;
  logic [7:0] module_mode [2];
  logic [7:0] priority_select;
  logic [7:0] priority_select_second;
  logic [15:0] compare_value [2];
  logic counter_overflow_flag;
  logic [1:0] module_event_flag;
  logic spi_done_flag;
  logic write_collision_flag;
  logic [1:0] cap_q;
  logic svc_hi;
  logic svc_lo;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire [7:0] idx = paddr[9:2];
  wire addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite && pready && ce;
  wire [7:0] wb = pwdata[7:0];
  wire hit_ie = addr_ok && idx == IDX_INT_ENABLE;
  wire hit_ie2 = addr_ok && idx == IDX_INT_ENABLE_SECOND;
  wire hit_stat = addr_ok && idx == IDX_SERIAL_PERIPH_STATUS;
  wire hit_dat = addr_ok && idx == IDX_SPI_DATA_REG;
  wire hit_ctl = addr_ok && idx == IDX_COUNTER_ARRAY_CONTROL;
  wire hit_mode = addr_ok && idx == IDX_COUNTER_ARRAY_MODE;
  wire hit_m0 = addr_ok && idx == IDX_COMPARE_MODULE0_MODE;
  wire hit_m1 = addr_ok && idx == IDX_COMPARE_MODULE1_MODE;
  wire hit_pr = addr_ok && idx == IDX_PRIORITY_SELECT;
  wire hit_pr2 = addr_ok && idx == IDX_PRIORITY_SELECT_SECOND;
  wire hit_c0 = addr_ok && idx == IDX_COMPARE_VALUE0;
  wire hit_c1 = addr_ok && idx == IDX_COMPARE_VALUE1;
  wire hit_st = addr_ok && idx == IDX_SERVICE_STATE;
  wire hit_any = hit_ie || hit_ie2 || hit_stat || hit_dat || hit_ctl || hit_mode || hit_m0
    || hit_m1 || hit_pr || hit_pr2 || hit_c0 || hit_c1 || hit_st;
  wire wr_stat = wr && hit_stat;
  wire wr_dat = wr && hit_dat;
  wire wr_ctl = wr && hit_ctl;

  wire [7:0] ctl_rd = {counter_overflow_flag, 5'b00000, module_event_flag};
  wire [7:0] stat_rd = {spi_done_flag, write_collision_flag, 6'b000000};
  wire [8:0] st_rd = {svc_hi, svc_lo, irq.req, irq.level, irq.num};
  wire [31:0] rd_mux =
    hit_ie ? {24'h000000, int_enable} :
    hit_ie2 ? {24'h000000, int_enable_second} :
    hit_stat ? {24'h000000, stat_rd} :
    hit_dat ? {24'h000000, spi_tx_data} :
    hit_ctl ? {24'h000000, ctl_rd} :
    hit_mode ? {24'h000000, counter_array_mode} :
    hit_m0 ? {24'h000000, module_mode[0]} :
    hit_m1 ? {24'h000000, module_mode[1]} :
    hit_pr ? {24'h000000, priority_select} :
    hit_pr2 ? {24'h000000, priority_select_second} :
    hit_c0 ? {16'h0000, compare_value[0]} :
    hit_c1 ? {16'h0000, compare_value[1]} :
    hit_st ? {23'h000000, st_rd} : 32'h00000000;

  // one access cycle: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready <= setup;
      prdata <= setup && !pwrite ? rd_mux : 32'h00000000;
      pslverr <= setup && !hit_any;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_enable <= RST_BYTE;
      int_enable_second <= RST_BYTE;
      counter_array_mode <= RST_BYTE;
      module_mode[0] <= RST_BYTE;
      module_mode[1] <= RST_BYTE;
      priority_select <= RST_BYTE;
      priority_select_second <= RST_BYTE;
    end
    else if (wr)
    begin
      if (hit_ie) int_enable <= wb;
      if (hit_ie2) int_enable_second <= wb;
      if (hit_mode) counter_array_mode <= wb;
      if (hit_m0) module_mode[0] <= wb;
      if (hit_m1) module_mode[1] <= wb;
      if (hit_pr) priority_select <= wb;
      if (hit_pr2) priority_select_second <= wb;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // counter array events
  wire [1:0] rise = counter_array.cap_pin & ~cap_q;
  wire [1:0] fall = ~counter_array.cap_pin & cap_q;
  logic [1:0] capture;
  logic [1:0] match;
  always_comb
  begin
    for (int m = 0; m < 2; m++)
    begin
      capture[m] = (module_mode[m][B_RISING_CAPTURE_EN] && rise[m])
        || (module_mode[m][B_FALLING_CAPTURE_EN] && fall[m]);
      match[m] = module_mode[m][B_MATCH_ENABLE] && counter_array.count == compare_value[m];
    end
  end
  wire [1:0] next_event = capture | match | (wr_ctl ? wb[1:0] : module_event_flag);
  wire next_ovf = counter_array.overflow || (wr_ctl ? wb[B_COUNTER_OVERFLOW_FLAG] : counter_overflow_flag);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_q <= 2'b00;
      counter_overflow_flag <= 1'b0;
      module_event_flag <= 2'b00;
      compare_value[0] <= RST_COMPARE;
      compare_value[1] <= RST_COMPARE;
    end
    else if (ce)
    begin
      cap_q <= counter_array.cap_pin;
      counter_overflow_flag <= next_ovf;
      module_event_flag <= next_event;
      for (int m = 0; m < 2; m++)
      begin
        if (capture[m]) compare_value[m] <= counter_array.count;
        else if (wr && (m == 0 ? hit_c0 : hit_c1)) compare_value[m] <= pwdata[15:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // spi flags
  wire mode_chg = spi.master && !spi.select_n && !spi.select_ignore;
  wire clr_done = wr_stat && wb[B_SPI_DONE_FLAG];
  wire clr_coll = wr_stat && wb[B_WRITE_COLLISION_FLAG];
  wire next_done = spi.done || mode_chg || (spi_done_flag && !clr_done);
  wire next_coll = (wr_dat && spi.busy) || (write_collision_flag && !clr_coll);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      spi_done_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      spi_tx_load <= 1'b0;
      spi_tx_data <= RST_BYTE;
    end
    else if (ce)
    begin
      spi_done_flag <= next_done;
      write_collision_flag <= next_coll;
      spi_tx_load <= wr_dat && !spi.busy;
      if (wr_dat && !spi.busy) spi_tx_data <= wb;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // request vectors and arbitration
  wire pca_irq = (counter_overflow_flag && counter_array_mode[B_OVERFLOW_IRQ_EN])
    || (module_event_flag[0] && module_mode[0][B_MODULE_EVENT_IRQ_EN])
    || (module_event_flag[1] && module_mode[1][B_MODULE_EVENT_IRQ_EN]);
  wire [23:0] flags = {src_flag[23:10], spi_done_flag, src_flag[8], pca_irq, src_flag[6:0]};
  wire [23:0] enables = {src_en[23:10], int_enable_second[B_SPI_IRQ_ENABLE],
    int_enable_second[B_SERIAL2_IRQ_EN], 1'b1, int_enable[6:0]};
  // sources without a level bit stay low
  wire [23:0] level = {priority_select_second[4:3], 5'b00000, priority_select_second[2], 6'b000000,
    priority_select_second[1:0], priority_select};
  wire [23:0] active = flags & enables & {NSRC{int_enable[B_GLOBAL_IRQ_GATE]}} & ~SRC_UNUSED;
  wire [23:0] hi_req = active & level;
  wire [23:0] lo_req = active & ~level;
  wire take_hi = |hi_req && !svc_hi;
  wire take_lo = |lo_req && !svc_hi && !svc_lo;
  wire [4:0] next_num = take_hi ? first_set(hi_req) : first_set(lo_req);
  wire acked = irq_ack && irq.req;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= '0;
      svc_hi <= 1'b0;
      svc_lo <= 1'b0;
    end
    else if (ce)
    begin
      irq.req <= (take_hi || take_lo) && !acked;
      irq.level <= take_hi;
      irq.num <= next_num;
      irq.vector <= vec_of(next_num);
      if (acked && irq.level) svc_hi <= 1'b1;
      else if (irq_reti && svc_hi) svc_hi <= 1'b0;
      if (acked && !irq.level) svc_lo <= 1'b1;
      else if (irq_reti && !svc_hi) svc_lo <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_match0;
    ce && module_mode[0][B_MATCH_ENABLE] && counter_array.count == compare_value[0];
  endsequence
  sequence s_ack_high;
    ce && irq.req && irq.level && irq_ack;
  endsequence
  sequence s_hi_pending;
    ce && |hi_req && !svc_hi && !acked;
  endsequence

  a_match_sets_flag: assert property (s_match0 |=> module_event_flag[0])
    else $error("match did not set event flag");
  a_ovf_gated: assert property (ce && !pca_irq |=> !(irq.req && irq.num == SRC_COUNTER_ARRAY))
    else $error("counter array request without enabled flag");
  a_spi_gated: assert property (ce && !int_enable_second[B_SPI_IRQ_ENABLE]
    |=> !(irq.req && irq.num == SRC_SPI))
    else $error("spi request while spi enable low");
  a_global_gate: assert property (ce && !int_enable[B_GLOBAL_IRQ_GATE] |=> !irq.req)
    else $error("request while global gate low");
  a_done_clear: assert property (ce && clr_done && !spi.done && !mode_chg |=> !spi_done_flag)
    else $error("done flag not cleared by write one");
  a_collision_set: assert property (ce && wr_dat && spi.busy |=> write_collision_flag)
    else $error("collision flag not set");
  a_high_blocks: assert property (ce && svc_hi |=> !irq.req)
    else $error("request during high routine");
  a_low_nesting: assert property (ce && svc_lo && !svc_hi |=> !irq.req || irq.level)
    else $error("low request preempted low routine");
  a_high_first: assert property (s_hi_pending |=> irq.req && irq.level
    && irq.num == $past(next_num))
    else $error("high level request not chosen");
  a_ack_high: assert property (s_ack_high |=> svc_hi ##0 !irq.req)
    else $error("high acknowledge not recorded");
  a_vector_map: assert property (irq.req |-> irq.vector == VEC_BASE + {8'h00, irq.num, 3'b000})
    else $error("vector does not match source");
  a_unused_src: assert property (irq.req |-> !SRC_UNUSED[irq.num])
    else $error("unused source number granted");
endmodule

// ==== tb/tlic_core_model.sv ====
`timescale 1ns/100ps
module tlic_core_model
  import tlic_pkg::*;
#(
  parameter int ACK_DELAY = 2
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire tlic_irq_t irq,
  input wire logic ack_on,
  input wire logic leave,
  output logic irq_ack,
  output logic irq_reti
);
  int wait_cnt;
  // takes a standing request after a delay, returns on request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_cnt <= 0;
      irq_ack <= 1'b0;
      irq_reti <= 1'b0;
    end
    else
    begin
      irq_reti <= leave;
      irq_ack <= 1'b0;
      wait_cnt <= 0;
      if (irq.req && ack_on && !irq_ack)
      begin
        wait_cnt <= wait_cnt + 1;
        irq_ack <= (wait_cnt >= ACK_DELAY);
      end
    end
  end
endmodule

// ==== tb/tlic_top_tb_top.sv ====
`timescale 1ns/100ps
module tlic_top_tb_top;
  import tlic_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  tlic_pca_t counter_array = 19'h00000;
  tlic_spi_t spi = 5'h02;
  logic [23:0] src_flag = 24'h000000;
  logic [23:0] src_en = 24'h000000;
  logic irq_ack;
  logic irq_reti;
  tlic_irq_t irq;
  logic ack_on = 1'b0;
  logic leave = 1'b0;
  logic ce = 1'b1;
  logic spi_tx_load;
  logic [7:0] spi_tx_data;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int tests_run = 0;
  logic [7:0] regs [6] = '{IDX_INT_ENABLE, IDX_INT_ENABLE_SECOND, IDX_SERIAL_PERIPH_STATUS,
    IDX_COUNTER_ARRAY_MODE, IDX_COMPARE_MODULE0_MODE, IDX_COMPARE_MODULE1_MODE};

  always #25 pclk = ~pclk;

  tlic_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counter_array(counter_array), .spi(spi), .src_flag(src_flag), .src_en(src_en),
    .irq_ack(irq_ack), .irq_reti(irq_reti), .irq(irq), .spi_tx_load(spi_tx_load), .spi_tx_data(spi_tx_data));

  tlic_core_model core_u (.pclk(pclk), .presetn(presetn), .irq(irq), .ack_on(ack_on),
    .leave(leave), .irq_ack(irq_ack), .irq_reti(irq_reti));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("mismatches %0d of %0d checks", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h00000000);
    chk(what, rd, exp);
  endtask

  task automatic irqchk(input logic req, input logic [4:0] num, input logic lvl);
    repeat (3) @(posedge pclk);
    chk("irq req", irq.req, req);
    if (req)
      chk("irq id", {irq.level, irq.num, irq.vector}, {lvl, num, VEC_BASE + {8'h00, num, 3'h0}});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) rdchk("reset value", regs[i], {24'h000000, RST_BYTE});
    wr(IDX_INT_ENABLE, 32'h0000005A);
    rdchk("enable rw", IDX_INT_ENABLE, 32'h0000005A);
    apb(1'b0, 8'h10, 32'h00000000);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h00000000);
    wr(IDX_INT_ENABLE, 32'h00000000);
    // transfer end, then the two gates
    spi.done <= 1'b1;
    @(posedge pclk);
    spi.done <= 1'b0;
    rdchk("spi done", IDX_SERIAL_PERIPH_STATUS, 32'h00000080);
    wr(IDX_INT_ENABLE_SECOND, 32'h00000002);
    irqchk(1'b0, 5'h00, 1'b0);
    wr(IDX_INT_ENABLE, 32'h00000080);
    irqchk(1'b1, SRC_SPI, 1'b0);
    wr(IDX_SERIAL_PERIPH_STATUS, 32'h00000000);
    rdchk("zero write", IDX_SERIAL_PERIPH_STATUS, 32'h00000080);
    wr(IDX_SERIAL_PERIPH_STATUS, 32'h00000080);
    rdchk("one write", IDX_SERIAL_PERIPH_STATUS, 32'h00000000);
    irqchk(1'b0, 5'h00, 1'b0);
    spi.busy <= 1'b1;
    wr(IDX_SPI_DATA_REG, 32'h00000055);
    rdchk("collision", IDX_SERIAL_PERIPH_STATUS, 32'h00000040);
    wr(IDX_SERIAL_PERIPH_STATUS, 32'h00000040);
    rdchk("collision clr", IDX_SERIAL_PERIPH_STATUS, 32'h00000000);
    spi.busy <= 1'b0;
    rdchk("no load", IDX_SPI_DATA_REG, 32'h00000000);
    // frozen clock enable: a transfer end is not seen
    ce <= 1'b0;
    spi.done <= 1'b1;
    @(posedge pclk);
    spi.done <= 1'b0;
    ce <= 1'b1;
    rdchk("frozen", IDX_SERIAL_PERIPH_STATUS, 32'h00000000);
    wr(IDX_SPI_DATA_REG, 32'h000000A5);
    @(posedge pclk);
    chk("tx load", {spi_tx_load, spi_tx_data}, 32'h000001A5);
    spi.master <= 1'b1;
    spi.select_n <= 1'b0;
    spi.select_ignore <= 1'b1;
    rdchk("select ignored", IDX_SERIAL_PERIPH_STATUS, 32'h00000000);
    spi.select_ignore <= 1'b0;
    rdchk("mode change", IDX_SERIAL_PERIPH_STATUS, 32'h00000080);
    spi.select_n <= 1'b1;
    spi.master <= 1'b0;
    wr(IDX_SERIAL_PERIPH_STATUS, 32'h00000080);
    // counter array flags
    wr(IDX_COUNTER_ARRAY_MODE, 32'h00000001);
    counter_array.overflow <= 1'b1;
    @(posedge pclk);
    counter_array.overflow <= 1'b0;
    rdchk("overflow", IDX_COUNTER_ARRAY_CONTROL, 32'h00000080);
    irqchk(1'b1, SRC_COUNTER_ARRAY, 1'b0);
    wr(IDX_COUNTER_ARRAY_MODE, 32'h00000000);
    irqchk(1'b0, 5'h00, 1'b0);
    rdchk("overflow held", IDX_COUNTER_ARRAY_CONTROL, 32'h00000080);
    wr(IDX_COUNTER_ARRAY_CONTROL, 32'h00000000);
    wr(IDX_COMPARE_VALUE0, 32'h00001234);
    wr(IDX_COMPARE_MODULE0_MODE, 32'h00000009);
    counter_array.count <= 16'h1234;
    rdchk("match", IDX_COUNTER_ARRAY_CONTROL, 32'h00000001);
    irqchk(1'b1, SRC_COUNTER_ARRAY, 1'b0);
    counter_array.count <= 16'h0000;
    wr(IDX_COUNTER_ARRAY_CONTROL, 32'h00000000);
    wr(IDX_COMPARE_MODULE0_MODE, 32'h00000000);
    wr(IDX_COMPARE_MODULE1_MODE, 32'h00000020);
    counter_array.count <= 16'h0777;
    counter_array.cap_pin[1] <= 1'b1;
    rdchk("rise capture", IDX_COMPARE_VALUE1, 32'h00000777);
    wr(IDX_COMPARE_MODULE1_MODE, 32'h00000010);
    counter_array.count <= 16'h0888;
    counter_array.cap_pin[1] <= 1'b0;
    rdchk("fall capture", IDX_COMPARE_VALUE1, 32'h00000888);
    rdchk("capture flag", IDX_COUNTER_ARRAY_CONTROL, 32'h00000002);
    irqchk(1'b0, 5'h00, 1'b0);
    wr(IDX_COUNTER_ARRAY_CONTROL, 32'h00000000);
    // levels, polling order and nesting
    wr(IDX_INT_ENABLE, 32'h00000083);
    src_en <= 24'h00E000;
    src_flag <= 24'h00E000;
    irqchk(1'b0, 5'h00, 1'b0);
    src_flag <= 24'h000003;
    irqchk(1'b1, 5'h00, 1'b0);
    wr(IDX_PRIORITY_SELECT, 32'h00000002);
    irqchk(1'b1, 5'h01, 1'b1);
    src_flag <= 24'h000001;
    irqchk(1'b1, 5'h00, 1'b0);
    ack_on <= 1'b1;
    repeat (8) @(posedge pclk);
    rdchk("low in service", IDX_SERVICE_STATE, 32'h00000080);
    ack_on <= 1'b0;
    src_flag <= 24'h000003;
    irqchk(1'b1, 5'h01, 1'b1);
    ack_on <= 1'b1;
    repeat (8) @(posedge pclk);
    rdchk("nested", IDX_SERVICE_STATE, 32'h00000180);
    src_flag <= 24'h000000;
    leave <= 1'b1;
    @(posedge pclk);
    leave <= 1'b0;
    rdchk("high left", IDX_SERVICE_STATE, 32'h00000080);
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    end_of_test();
  end
endmodule
